// File: dv/sac_comp_model.sv
// Purpose: Comparator stand-in on the far side of the converter
// Assumes: Decision level is chosen by the bench
// Notes:   Registered so the decision only moves on clock edges
`timescale 1ns/1ps
`default_nettype none
module sac_comp_model (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic decide,
    output logic      comp_in
);
    // A real comparator settles after the edge, never in mid-cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            comp_in <= 1'b0;
        end else begin
            comp_in <= decide;
        end
    end
endmodule
`default_nettype wire

// File: dv/sac_ctrl_bench.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Power-up calibration shortened to PCAL conversion-clock ticks
// Notes:   Phase lengths are timed from the edge that takes the start write
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_ctrl_bench;
    localparam int PCAL = 4;
    logic        ref_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic        awv     = 1'b0;
    logic        wv      = 1'b0;
    logic        brdy    = 1'b0;
    logic        arv     = 1'b0;
    logic        rrdy    = 1'b0;
    logic        decide  = 1'b0;
    logic [7:0]  awa     = 8'h00;
    logic [7:0]  ara     = 8'h00;
    logic [31:0] wd      = 32'h0000_0000;
    logic [3:0]  ws      = 4'h0;
    logic        awr, wr, bv, arr, rv, pwr, busy, smp, rval, comp;
    logic [1:0]  br, rr, resp;
    logic [31:0] rd, rdat;
    logic [4:0]  ch;
    logic [11:0] res;
    int          err_count   = 0;
    int          check_count = 0;
    int          take_t      = 0;

    always #2.5 ref_clk = ~ref_clk;

    sac_ctrl #(.PWRUP_CAL_CYC(PCAL)) dut (
        .ref_clk(ref_clk), .nrst(nrst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .comp_in(comp), .channel_select(ch), .powered(pwr), .busy(busy),
        .sampling(smp), .result_valid(rval), .result(res)
    );

    sac_comp_model comp_m (.ref_clk(ref_clk), .nrst(nrst), .decide(decide), .comp_in(comp));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            err_count++;
            $display("unexpected cycles at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data go out together; the slave only takes them as a pair
    // Response ready is set high by every call and never lowered, so it stays high between calls
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (bv) begin
                break;
            end
            if (awr) begin
                awv <= 1'b0;
                take_t = $time;
            end
            if (wr) begin
                wv <= 1'b0;
            end
        end
        resp = br;
    endtask

    task automatic axr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (rv) begin
                break;
            end
            if (arr) begin
                arv <= 1'b0;
            end
        end
        rdat = rd;
        resp = rr;
    endtask

    task automatic test_power();
        int rt;
        rt = $time;
        axw(`SAC_OFS_CTRL, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk_word(busy, 1'b0);
        rdat = 32'h0000_0000;
        while (rdat[0] !== 1'b1) begin
            axr(`SAC_OFS_STATUS);
        end
        // Polling granularity leaves a few cycles of slack above the count
        chk_word(($time - rt) / 5 - 2 >= PCAL * 4 && ($time - rt) / 5 <= PCAL * 4 + 8, 1'b1);
        $display("test power-up done");
    endtask

    task automatic test_regs();
        axr(`SAC_OFS_STATUS);
        // Mode 0 after reset powers down as soon as calibration leaves the sequencer idle
        chk_word(rdat, 32'h0000_0001);
        axr(`SAC_OFS_MODE);
        chk_word(rdat, {28'h0, `SAC_MODE_RST});
        axw(`SAC_OFS_TIMING, 32'h00AB_CDEF, 4'b0010);
        axr(`SAC_OFS_TIMING);
        chk_word(rdat, 32'h0000_CD00);
        axr(`SAC_OFS_CTRL);
        chk_word(rdat, 32'h0000_0000);
        axw(8'h14, 32'h0000_0001, 4'hF);
        chk_word(resp, 2'b10);
        axr(8'h14);
        chk_word(resp, 2'b10);
        $display("test registers done");
    endtask

    task automatic convert(input logic [3:0] m, input logic [7:0] dv, input logic [7:0] st,
                           input logic [4:0] c, input logic dec);
        int t;
        int n;
        int ts;
        logic [11:0] er;
        decide <= dec;
        axw(`SAC_OFS_MODE, {28'h0, m}, 4'hF);
        axw(`SAC_OFS_TIMING, {11'h0, c, st, dv}, 4'hF);
        axw(`SAC_OFS_CTRL, 32'h0000_0001, 4'hF);
        t = 4 * (1 + dv);
        n = (m[1:0] == 2'b01) ? 12 : ((m[1:0] == 2'b10) ? 8 : 10);
        er = dec ? (12'hFFF << (12 - n)) : 12'h000;
        ts = 0;
        forever begin
            @(posedge ref_clk);
            if (ts == 0 && smp !== 1'b1) begin
                ts = $time;
            end
            if (busy !== 1'b1) begin
                break;
            end
        end
        // Each level is seen one edge after the edge that changes it
        chk_cyc((ts - take_t) / 5 - 1, (2 + st) * t);
        chk_cyc(($time - take_t) / 5 - 1, (2 + st + n + (m[3] ? 0 : 2)) * t);
        chk_word(rval, 1'b1);
        chk_word(res, er);
        chk_word(ch, c);
        repeat (8) @(posedge ref_clk);
        chk_word(pwr, m[2]);
        chk_word(rval, 1'b1);
        $display("conversion mode %h done", m);
    endtask

    task automatic test_inject();
        repeat (20) @(posedge ref_clk);
        chk_word(rval, 1'b1);
        axw(`SAC_OFS_MODE, 32'h0000_0004, 4'hF);
        axw(`SAC_OFS_TIMING, 32'h0003_0504, 4'hF);
        axw(`SAC_OFS_CTRL, 32'h0000_0001, 4'hF);
        chk_word(rval, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk_word(smp, 1'b1);
        convert(4'h4, 8'd4, 8'd5, 5'd3, 1'b1);
        $display("test inject done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Longest scenario needs about 11,000 cycles; this leaves ample margin
    initial begin
        #300_000;
        err_count++;
        $display("unexpected hang at %0t: got %h expected %h", $time, 0, 1);
        test_done();
    end

    // Dividers 4..9 keep the conversion clock inside its legal band
    initial begin
        repeat (8) @(posedge ref_clk);
        chk_word({busy, smp, rval, pwr}, 4'b0001);
        nrst <= 1'b1;
        test_power();
        test_regs();
        convert(4'h0, 8'd4, 8'd0, 5'd0, 1'b1);
        convert(4'h5, 8'd5, 8'd3, 5'd31, 1'b1);
        convert(4'hA, 8'd9, 8'd255, 5'd7, 1'b1);
        convert(4'hF, 8'd4, 8'd1, 5'd16, 1'b0);
        test_inject();
        test_done();
    end
endmodule
`default_nettype wire

// File: verilog/sac_axil.sv
// Purpose: AXI4-Lite register slave for the converter sequencer
// Assumes: One write and one read at a time
// Notes:   Answers one cycle after both address and data are held
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_axil import sac_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire sac_status_s status,
    input  wire logic [11:0] result,
    output sac_cfg_s         cfg,
    output logic             start_pulse
);
    logic [3:0]  mode_r;
    logic [31:0] timing_r;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] rd_val;
    logic        rd_hit;

    // Both channels taken in the same cycle keeps the write path one state deep
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !s_axi_rvalid;
    assign cfg = '{mode: mode_r, clock_divide_value: timing_r[`SAC_TIM_DIV_LSB +: 8],
                   sample_time_value: timing_r[`SAC_TIM_STC_LSB +: 8],
                   channel_select: timing_r[`SAC_TIM_CH_LSB +: 5]};
    assign start_pulse = wr_go && s_axi_awaddr == `SAC_OFS_CTRL && s_axi_wstrb[0]
                         && s_axi_wdata[`SAC_CTRL_START];

    always_comb begin
        wr_hit = 1'b1;
        unique case (s_axi_awaddr)
            `SAC_OFS_CTRL, `SAC_OFS_MODE, `SAC_OFS_TIMING: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `SAC_OFS_CTRL:   rd_val = 32'h0000_0000;
            `SAC_OFS_MODE:   rd_val = {28'h000_0000, mode_r};
            `SAC_OFS_TIMING: rd_val = {11'h000, timing_r[20:0]};
            `SAC_OFS_STATUS: rd_val = {27'h000_0000, status};
            `SAC_OFS_RESULT: rd_val = {20'h0_0000, result};
            default:         rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r   <= `SAC_MODE_RST;
            timing_r <= `SAC_TIMING_RST;
        end else if (wr_go) begin
            if (s_axi_awaddr == `SAC_OFS_MODE && s_axi_wstrb[0]) begin
                mode_r <= s_axi_wdata[3:0];
            end
            if (s_axi_awaddr == `SAC_OFS_TIMING) begin
                for (int i = 0; i < 3; i++) begin
                    if (s_axi_wstrb[i]) begin
                        timing_r[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verilog/sac_clk_div.sv
// Purpose: Conversion clock tick generator
// Assumes: Divide value held stable during use
// Notes:   One tick every 4*(1+div) system clocks
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_clk_div import sac_pkg::*; (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       restart,
    input  wire logic [7:0] clock_divide_value,
    output logic            tick
);
    logic [9:0] cnt_r;
    logic [9:0] last;

    assign last = 10'(`SAC_CLK_MULT) * (10'(clock_divide_value) + 10'h001) - 10'h001;
    assign tick = (cnt_r == last) && !restart;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 10'h000;
        end else if (restart || cnt_r == last) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end
endmodule
`default_nettype wire

// File: verilog/sac_consts.svh
// Purpose: Constants for the converter sequencer
// Assumes: Included by bare name
// Notes:   Byte offsets and field positions of the register map
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_OFS_CTRL      8'h00
`define SAC_OFS_MODE      8'h04
`define SAC_OFS_TIMING    8'h08
`define SAC_OFS_STATUS    8'h0C
`define SAC_OFS_RESULT    8'h10

`define SAC_CTRL_START    0
`define SAC_MODE_NOCAL    3
`define SAC_MODE_NOPD     2
`define SAC_TIM_DIV_LSB   0
`define SAC_TIM_STC_LSB   8
`define SAC_TIM_CH_LSB    16

`define SAC_MODE_RST      4'h0
`define SAC_TIMING_RST    32'h0000_0000

`define SAC_CLK_MULT      4
`define SAC_SAMPLE_BASE   2
`define SAC_POSTCAL_CYC   2
`define SAC_PWRUP_CAL_CYC 3840
`define SAC_RES10         2'h0
`define SAC_RES12         2'h1
`define SAC_RES8          2'h2

`endif

// File: verilog/sac_ctrl.sv
// Purpose: Conversion sequencer of a successive-approximation converter
// Assumes: Comparator decision arrives as a level on the system clock
// Notes:   Registers reached over AXI4-Lite
// Operation
// - Mode bit 3 low adds two conversion-clock calibration cycles per conversion.
// - Mode bit 2 low powers the converter down after each conversion.
// - Mode bits 1:0 pick resolution: 00 ten, 01 twelve, 10 eight bits.
// - Conversion clock period is 4*(1+divide value) system clocks.
// - Inputs are taken on system clock edges; start begins a conversion.
// - Entering sample phase raises busy and sampling.
// - Sample phase lasts 2 plus sample time value conversion-clock periods.
// - Sampling falls at sample end; busy stays high through distribution.
// - Distribution takes N conversion-clock cycles, N the resolution.
// - Busy holds through post-calibration when enabled, else falls after distribution.
// - Result-valid rises as busy falls, with result presented.
// - Result-valid stays high until the next start.
// - Latency is sync, sample, distribution, calibration, sync delays; no sync delay is added at start or end.
// - Results sit MSB-justified on the 12-bit result.
// - A new start during a conversion abandons it and begins afresh.
// - After reset a 3840 conversion-clock power-up calibration runs first.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_ctrl import sac_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        comp_in,
    output logic [4:0]       channel_select,
    output logic             powered,
    output logic             busy,
    output logic             sampling,
    output logic             result_valid,
    output logic [11:0]      result
);
    parameter int unsigned PWRUP_CAL_CYC = `SAC_PWRUP_CAL_CYC;

    // The phase counter is 12 bits wide, so a longer calibration cannot be counted
    // Refused at elaboration rather than left to wrap silently
    if (PWRUP_CAL_CYC < 1 || PWRUP_CAL_CYC > 4095) begin : g_bad_pwrup
        $error("PWRUP_CAL_CYC out of range");
    end

    sac_state_e  state_r;
    sac_cfg_s    cfg;
    sac_cfg_s    held_r;
    sac_status_s status;
    logic        start_pulse;
    logic        tick;
    logic        comp_meta_r;
    logic        comp_sync_r;
    logic [11:0] cnt_r;
    logic [3:0]  nbits;
    logic [11:0] sar_r;
    logic        ready_r;
    logic        powered_r;
    logic [11:0] phase_end;
    logic [11:0] sar_nxt;
    logic        conv_done;

    sac_axil u_bus (
        .ref_clk       (ref_clk),
        .nrst          (nrst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .status        (status),
        .result        (result),
        .cfg           (cfg),
        .start_pulse   (start_pulse)
    );

    // Divider restarts on every accepted start so phase lengths are exact
    sac_clk_div u_div (
        .ref_clk            (ref_clk),
        .nrst               (nrst),
        .restart            (start_pulse && ready_r),
        .clock_divide_value (held_r.clock_divide_value),
        .tick               (tick)
    );

    assign status = '{busy: busy, sampling: sampling, result_valid: result_valid,
                      powered: powered_r, ready: ready_r};
    assign powered        = powered_r;
    assign channel_select = held_r.channel_select;

    // Code 11 is unused; it falls back to ten bits
    always_comb begin
        unique case (held_r.mode[1:0])
            `SAC_RES12: nbits = 4'd12;
            `SAC_RES8:  nbits = 4'd8;
            default:    nbits = 4'd10;
        endcase
    end

    always_comb begin
        phase_end = 12'h000;
        unique case (state_r)
            SAC_PWRUP:   phase_end = 12'(PWRUP_CAL_CYC - 1);
            SAC_SAMPLE:  phase_end = 12'(held_r.sample_time_value) + 12'(`SAC_SAMPLE_BASE - 1);
            SAC_DISTRIB: phase_end = 12'(nbits) - 12'h001;
            SAC_POSTCAL: phase_end = 12'(`SAC_POSTCAL_CYC - 1);
            default:     phase_end = 12'h000;
        endcase
    end

    // Last phase of a conversion ends here; busy falls and the result is
    // latched on this same edge
    assign conv_done = busy && tick && cnt_r == phase_end
                       && ((state_r == SAC_DISTRIB && held_r.mode[`SAC_MODE_NOCAL]) || state_r == SAC_POSTCAL);

    // The last decided bit must reach the result on the edge that ends distribution,
    // so the result is taken from the next value, not from the register
    always_comb begin
        sar_nxt = sar_r;
        if (tick && state_r == SAC_DISTRIB) begin
            sar_nxt[4'd11 - cnt_r[3:0]] = comp_sync_r;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end else begin
            comp_meta_r <= comp_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    // Settings latched at start shield the conversion from mid-flight writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            held_r <= '0;
        end else if (start_pulse && ready_r) begin
            held_r <= cfg;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SAC_PWRUP;
            cnt_r   <= 12'h000;
            ready_r <= 1'b0;
        end else if (start_pulse && ready_r) begin
            state_r <= SAC_SAMPLE;
            cnt_r   <= 12'h000;
        end else if (tick && state_r != SAC_IDLE) begin
            if (cnt_r == phase_end) begin
                cnt_r <= 12'h000;
                unique case (state_r)
                    SAC_PWRUP: begin
                        state_r <= SAC_IDLE;
                        ready_r <= 1'b1;
                    end
                    SAC_SAMPLE:  state_r <= SAC_DISTRIB;
                    SAC_DISTRIB: state_r <= held_r.mode[`SAC_MODE_NOCAL] ? SAC_IDLE : SAC_POSTCAL;
                    SAC_POSTCAL: state_r <= SAC_IDLE;
                    default:     state_r <= SAC_IDLE;
                endcase
            end else begin
                cnt_r <= cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy     <= 1'b0;
            sampling <= 1'b0;
        end else if (start_pulse && ready_r) begin
            busy     <= 1'b1;
            sampling <= 1'b1;
        end else if (tick && cnt_r == phase_end) begin
            if (state_r == SAC_SAMPLE) begin
                sampling <= 1'b0;
            end
            if ((state_r == SAC_DISTRIB && held_r.mode[`SAC_MODE_NOCAL]) || state_r == SAC_POSTCAL) begin
                busy <= 1'b0;
            end
        end
    end

    // One bit per distribution cycle, most significant first, so results stay MSB-justified
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sar_r <= 12'h000;
        end else if (start_pulse && ready_r) begin
            sar_r <= 12'h000;
        end else if (tick && state_r == SAC_DISTRIB) begin
            sar_r <= sar_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result_valid <= 1'b0;
            result       <= 12'h000;
        end else if (start_pulse && ready_r) begin
            result_valid <= 1'b0;
        end else if (conv_done) begin
            result_valid <= 1'b1;
            result       <= sar_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            powered_r <= 1'b1;
        end else if (start_pulse && ready_r) begin
            powered_r <= 1'b1;
        end else if (state_r == SAC_IDLE && ready_r && !held_r.mode[`SAC_MODE_NOPD]) begin
            powered_r <= 1'b0;
        end
    end

    a_busy_with_sample: assert property (@(posedge ref_clk) disable iff (!nrst)
        sampling |-> busy) else $error("sampling without busy");
    a_start_raises: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_pulse && ready_r |=> busy && sampling && !result_valid) else $error("start did not raise");
    a_valid_on_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(busy) && !$past(start_pulse) |-> result_valid) else $error("valid missing");
    a_valid_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        result_valid && !(start_pulse && ready_r) |=> result_valid) else $error("valid dropped");
    a_sample_to_dist: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(sampling) && !$past(start_pulse) |-> busy && state_r == SAC_DISTRIB) else $error("bad sample end");
    a_nocal_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
        held_r.mode[3] |-> state_r != SAC_POSTCAL) else $error("postcal when disabled");
    a_busy_in_cal: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_POSTCAL |-> busy) else $error("busy low in postcal");
    a_dist_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_DISTRIB |-> cnt_r < 12'(nbits)) else $error("distribution overrun");
    a_no_start_pwrup: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ready_r |-> !busy) else $error("busy before calibration");

    // Phase, power and result bookkeeping
    a_start_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_pulse && !ready_r |=> !busy) else $error("start taken before calibration");
    a_ready_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        ready_r |=> ready_r) else $error("ready dropped");
    a_idle_not_busy: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_IDLE |-> !busy) else $error("busy while idle");
    a_sample_state: assert property (@(posedge ref_clk) disable iff (!nrst)
        sampling == (state_r == SAC_SAMPLE)) else $error("sampling out of phase");
    a_chan_held: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(start_pulse && ready_r) |=> $stable(channel_select)) else $error("channel moved mid conversion");
    a_power_on_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_pulse && ready_r |=> powered) else $error("not powered at start");
    a_power_down_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_IDLE && ready_r && !held_r.mode[`SAC_MODE_NOPD] && !start_pulse |=> !powered)
        else $error("still powered after conversion");
    a_result_held: assert property (@(posedge ref_clk) disable iff (!nrst)
        !conv_done |=> $stable(result)) else $error("result moved");
    a_result_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
        conv_done && !start_pulse |=> result == $past(sar_nxt)) else $error("result not latched");
    a_sar_cleared: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_pulse && ready_r |=> sar_r == 12'h000) else $error("stale bits after start");
    a_res8_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        conv_done && held_r.mode[1:0] == `SAC_RES8 |-> sar_nxt[3:0] == 4'h0) else $error("8-bit result low bits set");
    a_res10_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        conv_done && held_r.mode[1:0] != `SAC_RES12 |-> sar_nxt[1:0] == 2'h0) else $error("short result low bits set");

    // Main scenarios the bench is expected to reach
    c_conv_cal: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_POSTCAL ##1 state_r == SAC_IDLE);
    c_conv_nocal: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_r == SAC_DISTRIB ##1 state_r == SAC_IDLE);
    c_injected: cover property (@(posedge ref_clk) disable iff (!nrst)
        busy && start_pulse && ready_r);
    c_power_down: cover property (@(posedge ref_clk) disable iff (!nrst)
        $fell(powered));
    c_res12: cover property (@(posedge ref_clk) disable iff (!nrst)
        conv_done && held_r.mode[1:0] == `SAC_RES12);
endmodule
`default_nettype wire

// File: verilog/sac_pkg.sv
// Purpose: Types for the converter sequencer
// Assumes: Nothing
// Notes:   Constants live in the header
package sac_pkg;
    typedef enum logic [2:0] {
        SAC_IDLE, SAC_PWRUP, SAC_SAMPLE, SAC_DISTRIB, SAC_POSTCAL
    } sac_state_e;

    typedef struct packed {
        logic       busy;
        logic       sampling;
        logic       result_valid;
        logic       powered;
        logic       ready;
    } sac_status_s;

    typedef struct packed {
        logic [3:0] mode;
        logic [7:0] clock_divide_value;
        logic [7:0] sample_time_value;
        logic [4:0] channel_select;
    } sac_cfg_s;
endpackage
